// file: operating_watchdog_map.svh
`ifndef OPERATING_WATCHDOG_MAP_SVH
`define OPERATING_WATCHDOG_MAP_SVH

// Counter widths and reset values
`define WDOG_PRESCALE_WIDTH   4
`define WDOG_COUNT_WIDTH      12
`define WDOG_PRESCALE_RESET   4'h0
`define WDOG_COUNT_RESET      12'h000
`define WDOG_RESET_PULSE      4'h8
`define WDOG_PULSE_LAST       4'h1
`define WDOG_PULSE_IDLE       4'h0
`define WDOG_SYNC_RESET       2'h0

`endif

// file: operating_watchdog_pkg.sv
`include "operating_watchdog_map.svh"

package operating_watchdog_pkg;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_HOLD  = 3'b010,
    ST_RESET = 3'b100
  } wdog_state_e;

  typedef struct packed {
    wdog_state_e                     state;
    logic [1:0]                      hv_sync;
    logic [`WDOG_PRESCALE_WIDTH-1:0] prescale;
    logic [`WDOG_COUNT_WIDTH-1:0]    count;
    logic [3:0]                      pulse_cnt;
    logic                            sys_reset;
  } wdog_regs_s;

endpackage : operating_watchdog_pkg

// file: operating_watchdog.sv
`timescale 1ns/1ps
// Behaviour
// - Free-running counter forces a system reset when it overflows.
// - Disable bit in first system configuration register stops the watchdog.
// - Stop mode gates the doubled oscillator clock and, while running, clears the prescaler.
// - Watchdog held disabled during break while reset pin has test voltage.
module operating_watchdog
  import operating_watchdog_pkg::*;
#(
  parameter int PRESCALE_WIDTH = `WDOG_PRESCALE_WIDTH,
  parameter int COUNT_WIDTH    = `WDOG_COUNT_WIDTH
) (
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  input  wire logic i_doubled_oscillator_clock_tick,
  input  wire logic i_watchdog_disable_bit,
  input  wire logic i_stop_mode,
  input  wire logic i_break_active,
  input  wire logic i_reset_pin_high_voltage,
  input  wire logic i_watchdog_control_register_write,
  output logic      o_system_reset,
  output logic      o_running
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  ////////////////////////////////////////////////////////////////////////////

  // The state struct takes its widths from the map header, so the
  // parameters can only restate them; anything else is refused here
  initial begin
    if (PRESCALE_WIDTH != `WDOG_PRESCALE_WIDTH) begin
      $error("Watchdog prescaler width must match the map header");
    end
    if (COUNT_WIDTH != `WDOG_COUNT_WIDTH) begin
      $error("Watchdog counter width must match the map header");
    end
    if (PRESCALE_WIDTH < 1) begin
      $error("Watchdog prescaler needs at least one bit");
    end
    if (COUNT_WIDTH < 1) begin
      $error("Watchdog counter needs at least one bit");
    end
    if (`WDOG_RESET_PULSE == `WDOG_PULSE_IDLE) begin
      $error("Watchdog reset pulse must last at least one cycle");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset image of the whole state
  ////////////////////////////////////////////////////////////////////////////

  localparam wdog_regs_s REGS_RESET = '{
    state:     ST_RUN,
    hv_sync:   `WDOG_SYNC_RESET,
    prescale:  `WDOG_PRESCALE_RESET,
    count:     `WDOG_COUNT_RESET,
    pulse_cnt: `WDOG_PULSE_IDLE,
    sys_reset: 1'b0
  };

  ////////////////////////////////////////////////////////////////////////////
  // Next-state helpers
  ////////////////////////////////////////////////////////////////////////////

  // Break with test voltage suspends without clearing, so debug can resume
  function automatic logic suspend_now(
    input logic disable_bit,
    input logic break_on,
    input logic hv_seen
  );
    return disable_bit || (break_on && hv_seen);
  endfunction : suspend_now

  // True on the tick that would carry out of both counters
  function automatic logic overflow_due(input wdog_regs_s r);
    return (&r.prescale) && (&r.count);
  endfunction : overflow_due

  // Software service restarts the full period from zero
  function automatic wdog_regs_s clear_counts(input wdog_regs_s r);
    wdog_regs_s c;

    c          = r;
    c.prescale = `WDOG_PRESCALE_RESET;
    c.count    = `WDOG_COUNT_RESET;
    return c;
  endfunction : clear_counts

  // One doubled-oscillator tick: prescaler first, counter on its wrap,
  // and the reset pulse when both are at their top value
  function automatic wdog_regs_s count_tick(input wdog_regs_s r);
    wdog_regs_s c;

    c          = r;
    c.prescale = r.prescale + 1'b1;
    if (overflow_due(r)) begin
      c.state     = ST_RESET;
      c.sys_reset = 1'b1;
      c.pulse_cnt = `WDOG_RESET_PULSE;
      c.count     = `WDOG_COUNT_RESET;
    end else if (&r.prescale) begin
      c.count = r.count + 1'b1;
    end
    return c;
  endfunction : count_tick

  // Running: suspension beats service, service beats stop, stop beats ticks
  function automatic wdog_regs_s run_next(
    input wdog_regs_s r,
    input logic       hold_now,
    input logic       service,
    input logic       stopped,
    input logic       tick
  );
    wdog_regs_s c;

    c = r;
    if (hold_now) begin
      c.state = ST_HOLD;
    end else if (service) begin
      c = clear_counts(r);
    end else if (stopped) begin
      // Stop gates the tick and clears the prescaler; the counter keeps its value
      c.prescale = `WDOG_PRESCALE_RESET;
    end else if (tick) begin
      c = count_tick(r);
    end
    return c;
  endfunction : run_next

  // Held: counts stay frozen, but a service write still clears them
  function automatic wdog_regs_s hold_next(
    input wdog_regs_s r,
    input logic       hold_now,
    input logic       service
  );
    wdog_regs_s c;

    c = r;
    if (service) begin
      c = clear_counts(r);
    end
    if (!hold_now) begin
      c.state = ST_RUN;
    end
    return c;
  endfunction : hold_next

  // The pulse lasts several cycles so that every module of the chip sees it
  function automatic wdog_regs_s pulse_next(input wdog_regs_s r);
    wdog_regs_s c;

    c          = r;
    c.prescale = `WDOG_PRESCALE_RESET;
    if (r.pulse_cnt == `WDOG_PULSE_LAST) begin
      c.sys_reset = 1'b0;
      c.pulse_cnt = `WDOG_PULSE_IDLE;
      c.state     = ST_RUN;
    end else begin
      c.pulse_cnt = r.pulse_cnt - 1'b1;
    end
    return c;
  endfunction : pulse_next

  ////////////////////////////////////////////////////////////////////////////
  // State register
  ////////////////////////////////////////////////////////////////////////////

  wdog_regs_s regs_q;
  wdog_regs_s regs_d;
  logic       suspended;
  logic       tick_en;

  // The voltage detector is asynchronous; only the second stage is read,
  // so a break with test voltage takes effect two cycles late
  assign suspended = suspend_now(i_watchdog_disable_bit, i_break_active, regs_q.hv_sync[1]);
  assign tick_en   = i_doubled_oscillator_clock_tick && !i_stop_mode;

  // The synchroniser shifts in every state, including the reset pulse,
  // so the detector is settled whenever the counting states resume
  always_comb begin
    regs_d         = regs_q;
    regs_d.hv_sync = {regs_q.hv_sync[0], i_reset_pin_high_voltage};
    case (regs_q.state)
      ST_RUN: begin
        regs_d = run_next(regs_d, suspended, i_watchdog_control_register_write, i_stop_mode, tick_en);
      end
      ST_HOLD: begin
        regs_d = hold_next(regs_d, suspended, i_watchdog_control_register_write);
      end
      ST_RESET: begin
        regs_d = pulse_next(regs_d);
      end
      default: begin
        regs_d.state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      regs_q <= REGS_RESET;
    end else begin
      regs_q <= regs_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  ////////////////////////////////////////////////////////////////////////////

  // o_system_reset comes straight from the state register; o_running is decoded from its registered state field
  assign o_system_reset = regs_q.sys_reset;
  assign o_running      = (regs_q.state == ST_RUN);

endmodule : operating_watchdog

// file: operating_watchdog_asserts.sv
`timescale 1ns/1ps
module operating_watchdog_asserts (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_doubled_oscillator_clock_tick,
  input wire logic i_watchdog_disable_bit,
  input wire logic i_stop_mode,
  input wire logic i_break_active,
  input wire logic i_reset_pin_high_voltage,
  input wire logic i_watchdog_control_register_write,
  input wire logic o_system_reset,
  input wire logic o_running
);
  default clocking dc @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  pulse_length_a: assert property ($rose(o_system_reset) |-> o_system_reset[*8] ##1 !o_system_reset)
    else $error("reset pulse length wrong");
  pulse_idle_a: assert property (o_system_reset |-> !o_running)
    else $error("running during reset pulse");
  disable_quiet_a: assert property (i_watchdog_disable_bit[*3] |-> !$rose(o_system_reset))
    else $error("reset while disabled");
  // Stop gates the tick at once without leaving the run state; two cycles leave one spare
  stop_quiet_a: assert property (i_stop_mode[*2] |-> !$rose(o_system_reset))
    else $error("reset while stopped");
  break_quiet_a: assert property ((i_break_active && i_reset_pin_high_voltage)[*4] |-> !$rose(o_system_reset))
    else $error("reset during break");
  write_clear_a: assert property (i_watchdog_control_register_write && !o_system_reset |=> !o_system_reset[*8])
    else $error("reset soon after write");
endmodule : operating_watchdog_asserts
////////////////////////////////////////////////////////////////
bind operating_watchdog operating_watchdog_asserts i_chk (.i_clk_sys, .i_reset, .i_doubled_oscillator_clock_tick,
  .i_watchdog_disable_bit, .i_stop_mode, .i_break_active, .i_reset_pin_high_voltage,
  .i_watchdog_control_register_write, .o_system_reset, .o_running);

// file: operating_watchdog_test.sv
`timescale 1ns/1ps
module operating_watchdog_test;
  logic i_clk_sys, i_reset, i_doubled_oscillator_clock_tick, i_watchdog_disable_bit;
  logic i_stop_mode, i_break_active, i_reset_pin_high_voltage, i_watchdog_control_register_write;
  logic o_system_reset, o_running;
  int   n_mismatch, n_tests, k, h;
  typedef struct packed {logic [3:0] cond; logic [4:0] n; logic r;} row_s;
  // Count sits one tick short of overflow; held rows must not reach it, stop drops 15 prescale ticks
  row_s rows [5] = '{'{4'h8, 5'h04, 1'h0}, '{4'h3, 5'h04, 1'h0}, '{4'h4, 5'h04, 1'h0},
                     '{4'h0, 5'h0f, 1'h0}, '{4'h0, 5'h01, 1'h1}};
  always #12.5 i_clk_sys = ~i_clk_sys;
  operating_watchdog i_operating_watchdog (.i_clk_sys, .i_reset, .i_doubled_oscillator_clock_tick,
    .i_watchdog_disable_bit, .i_stop_mode, .i_break_active, .i_reset_pin_high_voltage,
    .i_watchdog_control_register_write, .o_system_reset, .o_running);
  ////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task tk(input int n);
    i_doubled_oscillator_clock_tick = 1'b1;
    repeat (n) @(negedge i_clk_sys);
    i_doubled_oscillator_clock_tick = 1'b0;
  endtask : tk
  task conclude;
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////
  initial begin
    i_clk_sys = 1'b0;
    i_reset = 1'b1;
    {i_doubled_oscillator_clock_tick, i_watchdog_disable_bit, i_stop_mode} = 3'h0;
    {i_break_active, i_reset_pin_high_voltage, i_watchdog_control_register_write} = 3'h0;
    repeat (16) @(negedge i_clk_sys);
    i_reset = 1'b0;
    chk(o_running, 16'h0001);
    chk(o_system_reset, 16'h0000);
    // A write midway must push the overflow out by a full period
    tk(30000);
    i_watchdog_control_register_write = 1'b1;
    @(negedge i_clk_sys);
    i_watchdog_control_register_write = 1'b0;
    tk(65535);
    chk(o_system_reset, 16'h0000);
    for (k = 0; k < 5; k++) begin
      {i_watchdog_disable_bit, i_stop_mode, i_break_active, i_reset_pin_high_voltage} = rows[k].cond;
      // Idle cycles let the two-stage voltage synchroniser settle
      repeat (3) @(negedge i_clk_sys);
      tk(rows[k].n);
      chk(o_system_reset, 16'(rows[k].r));
    end
    chk(o_running, 16'h0000);
    h = 1;
    repeat (20) begin
      @(negedge i_clk_sys);
      if (o_system_reset === 1'b1) h++;
    end
    chk(16'(h), 16'h0008);
    chk(o_running, 16'h0001);
    // Service right before stop, tick through stop, no reset on leaving
    i_watchdog_control_register_write = 1'b1;
    @(negedge i_clk_sys);
    i_watchdog_control_register_write = 1'b0;
    i_stop_mode = 1'b1;
    tk(4);
    i_stop_mode = 1'b0;
    chk(o_system_reset, 16'h0000);
    conclude();
  end
endmodule : operating_watchdog_test
